// *** tb/target_bus_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Target processor bus: one call makes one bus cycle.
module target_bus_model (
  // Clock.
  input wire logic pclk,
  // Bus cycle towards the qualifier.
  output logic cyc_valid,
  output logic cyc_io,
  output logic cyc_write,
  output logic instruction_fetch_cycle,
  output logic [15:0] cyc_addr,
  output logic [15:0] cyc_data,
  output logic [7:0] cyc_ext
);
  // Idle bus at time zero.
  initial begin
    cyc_valid = 1'b0;
    cyc_io = 1'b0;
    cyc_write = 1'b0;
    instruction_fetch_cycle = 1'b0;
    cyc_addr = 16'h0000;
    cyc_data = 16'h0000;
    cyc_ext = 8'h00;
  end

  // A released bus keeps no value, so the address, data and extended lines are inverted after each cycle.
  task automatic run(input logic io, input logic wr, input logic f, input logic [15:0] ad,
                     input logic [15:0] dt, input logic [7:0] ex);
    @(posedge pclk);
    cyc_valid <= 1'b1;
    cyc_io <= io;
    cyc_write <= wr;
    instruction_fetch_cycle <= f;
    cyc_addr <= ad;
    cyc_data <= dt;
    cyc_ext <= ex;
    @(posedge pclk);
    cyc_valid <= 1'b0;
    cyc_addr <= ~ad;
    cyc_data <= ~dt;
    cyc_ext <= ~ex;
  endtask
endmodule

// *** tb/tb_io_and_opcode_range_trace_qualifier.sv ***
`timescale 1ns/1ps
module tb_io_and_opcode_range_trace_qualifier;
  import trace_qual_pkg::*;
  // ==========================================================
  // Signals and counters.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic cyc_valid, cyc_io, cyc_write, instruction_fetch_cycle;
  logic [15:0] cyc_addr, cyc_data, sample_addr, sample_data;
  logic [7:0] cyc_ext, sample_ext;
  logic sample_store, sample_is_io, fetch_seen, trace_active;
  int num_errors = 0;
  int n_tests = 0;

  always #10 pclk = ~pclk;

  io_and_opcode_range_trace_qualifier io_and_opcode_range_trace_qualifier_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_write(cyc_write),
    .instruction_fetch_cycle(instruction_fetch_cycle), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
    .cyc_ext(cyc_ext), .sample_store(sample_store), .sample_is_io(sample_is_io),
    .sample_addr(sample_addr), .sample_data(sample_data), .sample_ext(sample_ext),
    .fetch_seen(fetch_seen), .trace_active(trace_active));

  target_bus_model target_bus_model_inst (
    .pclk(pclk), .cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_write(cyc_write),
    .instruction_fetch_cycle(instruction_fetch_cycle), .cyc_addr(cyc_addr),
    .cyc_data(cyc_data), .cyc_ext(cyc_ext));

  // ==========================================================
  // Verdict and comparison helpers.
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  // Expected-value models.
  function automatic logic in_rng(logic [15:0] a1, logic [15:0] a2, logic [15:0] a, logic rng);
    if (!rng) return a == a1 || a == a2;
    if (a1 <= a2) return a >= a1 && a <= a2;
    return a >= a1 || a <= a2;
  endfunction

  function automatic logic ext_ok(logic [7:0] xc, logic [7:0] xm, logic [3:0] xa, logic [7:0] ex);
    return ((ex ^ xc) & xm & (8'hFF >> xa)) == 8'h00;
  endfunction

  function automatic logic mem_ok(int code, logic wr, logic f);
    case (code)
      1: return 1'b1;
      2: return !wr;
      3: return wr && !f;
      4: return f;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // APB master; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, read data and the error flag are all taken at the rising edge that ends the access.
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      $display("ERROR at %0t: APB transfer timed out", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input int unsigned idx, input logic [31:0] v);
    apb(1'b1, 8'(idx * 4), v);
  endtask

  // One bus cycle and the check of the sample that must or must not follow it.
  task automatic cyc(input logic io, input logic wr, input logic f, input logic [15:0] ad,
                     input logic [15:0] dt, input logic [7:0] ex, input logic exp);
    target_bus_model_inst.run(io, wr, f, ad, dt, ex);
    #1;
    chk(sample_store === exp, "sample store");
    if (exp) chk(sample_is_io === io && sample_addr === (io ? ad & IO_ADDR_MASK : ad) &&
                 sample_data === dt && sample_ext === ex, "sample fields");
  endtask

  task automatic fetch(input logic [15:0] op, input logic exp);
    cyc(1'b0, 1'b0, 1'b1, 16'h0120, op, 8'h00, exp);
    chk(fetch_seen === exp, "fetch seen flag");
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    logic [15:0] a1, a2, ad;
    logic [7:0] xc, xm, ex;
    logic [3:0] xa;
    logic rng, io, exp_io;
    void'($urandom(32'h314F));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(sample_store === 1'b0 && trace_active === 1'b0 && fetch_seen === 1'b0, "reset outputs");
    apb(1'b0, 8'(REG_STATUS * 4), 32'h0);
    chk(rd === 32'h0 && err === 1'b0, "status reset");
    apb(1'b0, 8'h38, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    // A live main data compare must not touch I/O qualification.
    wr_reg(REG_MEM_DATA, 32'hFFFF_A5A5);
    // Random I/O qualification; the last pass turns the qualifier off.
    for (int k = 0; k < 6; k++) begin
      a1 = 16'($urandom_range(0, 16'h7FFF));
      a2 = 16'($urandom_range(0, 16'h7FFF));
      rng = k[0];
      xa = 4'($urandom_range(0, 8));
      xc = 8'($urandom);
      xm = 8'($urandom);
      wr_reg(REG_CTRL, {24'h0, xa, 4'h0});
      wr_reg(REG_IO_ADDR1, {16'h0, a1});
      wr_reg(REG_IO_ADDR2, {16'h0, a2});
      wr_reg(REG_IO_CFG, {8'h0, xm, xc, 4'h0, rng, 2'h0, 1'(k < 5)});
      for (int j = 0; j < 12; j++) begin
        io = 1'($urandom);
        ad = (j % 3 == 0) ? a1 : (j % 3 == 1) ? a2 : 16'($urandom);
        ad[15] = 1'($urandom);
        ex = 8'($urandom);
        exp_io = io && k < 5 && in_rng(a1, a2, ad & IO_ADDR_MASK, rng);
        exp_io = exp_io && ext_ok(xc, xm, xa, ex);
        cyc(io, 1'($urandom), 1'b0, ad, 16'($urandom), ex, exp_io);
      end
      chk(trace_active === (k < 5), "io trace active");
    end
    // Every memory qualifier code over the full address range.
    wr_reg(REG_IO_CFG, 32'h0);
    wr_reg(REG_MEM_DATA, 32'h0);
    wr_reg(REG_CTRL, 32'h0);
    wr_reg(REG_MEM_ADDR2, 32'h0000_FFFF);
    for (int code = 0; code < 8; code++) begin
      wr_reg(REG_MEM_CFG, 32'h8 | code);
      for (int j = 0; j < 3; j++) begin
        cyc(1'b0, j == 1, j == 2, 16'($urandom), 16'($urandom), 8'($urandom),
            mem_ok(code, j == 1, j == 2));
      end
      if (code < 5) chk(trace_active === (code != 0), "mem trace active");
    end
    // Instruction-range mode: arm on a fetch in range, disarm on the next fetch outside it.
    wr_reg(REG_MEM_CFG, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_IX_ADDR1, 32'h0100);
    wr_reg(REG_IX_ADDR2, 32'h01FF);
    wr_reg(REG_IX_CFG, 32'h19);
    // The activity flag follows the configuration one edge later.
    @(posedge pclk);
    #1;
    chk(trace_active === 1'b1, "range trace active");
    cyc(1'b0, 1'b0, 1'b0, 16'h5000, 16'hA5A5, 8'h00, 1'b0);
    fetch(16'h1234, 1'b1);
    cyc(1'b0, 1'b1, 1'b0, 16'h9000, 16'h0F0F, 8'h00, 1'b1);
    cyc(1'b1, 1'b0, 1'b0, 16'hFFFF, 16'h3C3C, 8'h00, 1'b1);
    cyc(1'b0, 1'b0, 1'b1, 16'h0300, 16'h1234, 8'h00, 1'b0);
    chk(fetch_seen === 1'b0, "flag cleared");
    cyc(1'b0, 1'b0, 1'b0, 16'h9000, 16'h0F0F, 8'h00, 1'b0);
    // Opcode range set: add two ranges and a duplicate, delete one, then disable the filter.
    wr_reg(REG_CTRL, 32'h3);
    wr_reg(REG_OPC_BOUNDS, 32'h10F0_1000);
    wr_reg(REG_OPC_CMD, 32'h1);
    wr_reg(REG_OPC_BOUNDS, 32'h2000_2000);
    wr_reg(REG_OPC_CMD, 32'h1);
    wr_reg(REG_OPC_CMD, 32'h1);
    apb(1'b0, 8'(REG_STATUS * 4), 32'h0);
    chk(rd[15:8] === 8'h02, "ranges used");
    fetch(16'h10FF, 1'b1);
    fetch(16'h1100, 1'b0);
    fetch(16'h200F, 1'b1);
    fetch(16'h0FFF, 1'b0);
    wr_reg(REG_OPC_BOUNDS, 32'h10F0_1000);
    wr_reg(REG_OPC_CMD, 32'h0);
    fetch(16'h1005, 1'b0);
    fetch(16'h200A, 1'b1);
    wr_reg(REG_CTRL, 32'h1);
    fetch(16'h1005, 1'b1);
    wr_reg(REG_CTRL, 32'h101);
    @(posedge pclk);
    #1;
    chk(fetch_seen === 1'b0, "run start clears flag");
    finish_test();
  end
endmodule

// *** verilog/io_and_opcode_range_trace_qualifier.sv ***
// Overview of operation
// - I/O qualifier code zero records no I/O samples.
// - I/O code one qualifies any I/O read or write at matching port.
// - I/O addresses are bit numbers; bit 15 is ignored in compares.
// - Range off: exact match to either address; on: between them.
// - First address above second inverts the range test.
// - I/O qualifying uses no data word compare, only extended byte.
// - I/O samples take bus data as data from the addressed port.
// - I/O settings are held apart from memory settings.
// - Extended byte compared under mask, ones enable each bit.
// - Fetched opcode is ANDed with FFF0 before bound compares.
// - Opcode ranges accumulate; code one adds, zero deletes.
// - Opcode enable clear means the range set is ignored.
// - Qualified fetch in instruction-range mode sets the seen flag.
// - Next unqualified fetch clears a set seen flag.
// - Flag set plus memory or I/O qualifier stores, any address.
// - Instruction-range qualifier codes mean the same as separate ones.
// - Mode selects separate qualifiers or fetch-only range test.
// - Tracing stays active until every qualifier of the selected mode is off.
// - Memory codes: off, any, read or fetch, write, fetch only.
// - Eight extended bits split into address and data fields.
// - Mode one is instruction-range, mode zero separate qualifiers.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module io_and_opcode_range_trace_qualifier
  import trace_qual_pkg::*;
#(
  parameter int unsigned NUM_RANGES = 8
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Target bus cycle, same clock.
  input wire logic cyc_valid,
  input wire logic cyc_io,
  input wire logic cyc_write,
  input wire logic instruction_fetch_cycle,
  input wire logic [15:0] cyc_addr,
  input wire logic [15:0] cyc_data,
  input wire logic [7:0] cyc_ext,
  // Trace sample out.
  output logic sample_store,
  output logic sample_is_io,
  output logic [15:0] sample_addr,
  output logic [15:0] sample_data,
  output logic [7:0] sample_ext,
  output logic fetch_seen,
  output logic trace_active
);

  // The used-slot count in the status word is eight bits wide, which bounds the set.
  if (NUM_RANGES < 1 || NUM_RANGES > 255) begin : bad_ranges
    $error("NUM_RANGES must be 1 to 255.");
  end

  // ==========================================================
  // Helper functions
  // Address test shared by memory, I/O and fetch qualifiers.
  function automatic logic addr_ok(input logic [15:0] a, input logic [15:0] a1,
                                   input logic [15:0] a2, input logic rng);
    if (!rng) begin
      addr_ok = (a == a1) || (a == a2);
    end else if (a1 <= a2) begin
      addr_ok = (a >= a1) && (a <= a2);
    end else begin
      addr_ok = (a >= a1) || (a <= a2);
    end
  endfunction

  // Extended data field sits in the low bits left over after address bits.
  function automatic logic ext_ok(input logic [7:0] x, input logic [31:0] q,
                                  input logic [3:0] nb);
    logic [7:0] field;
    field = (nb >= EXT_BITS) ? 8'h00 : (EXT_ALL >> nb);
    ext_ok = ((x ^ q[QUAL_XCMP_LSB +: 8]) & q[QUAL_XMASK_LSB +: 8] & field) == 8'h00;
  endfunction

  // Memory qualifier code against cycle kind.
  function automatic logic mem_ok(input logic [2:0] code, input logic wr, input logic fe);
    unique case (code)
      mem_any_access: mem_ok = 1'b1;
      mem_read_access: mem_ok = !wr;
      mem_write_access: mem_ok = wr;
      mem_fetch_only: mem_ok = fe;
      default: mem_ok = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // APB register file
  logic [31:0] cfg [0:NUM_REGS-1];
  logic [31:0] status_word;
  logic wr_en;
  logic [3:0] reg_idx;
  logic idx_ok;
  logic run_pulse;
  logic opc_cmd_pulse;

  assign reg_idx = paddr[5:2];
  assign idx_ok = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) && (reg_idx < NUM_REGS);
  assign wr_en = psel && penable && pready && pwrite && idx_ok;
  assign run_pulse = wr_en && (reg_idx == REG_CTRL) && pwdata[CTRL_RUN_BIT];
  assign opc_cmd_pulse = wr_en && (reg_idx == REG_OPC_CMD);

  // Each setup has its own words; memory and I/O share only the extended address-bit count in the control word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= REG_RESET;
      end
    end else if (wr_en && reg_idx != REG_STATUS && reg_idx != REG_OPC_CMD) begin
      cfg[reg_idx] <= pwdata;
    end
  end

  // One wait-free answer: ready rises in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !idx_ok;
      if (psel && !penable && !pwrite && idx_ok) begin
        if (reg_idx == REG_STATUS) begin
          prdata <= status_word;
        end else if (reg_idx == REG_OPC_CMD) begin
          prdata <= 32'h0000_0000;
        end else begin
          prdata <= cfg[reg_idx];
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Field decode
  logic mode;
  logic opc_en;
  logic [3:0] xa_bits;
  logic [2:0] mem_code;
  logic io_code;
  logic [2:0] ix_mem_code;
  logic ix_io_code;
  logic next_active;

  assign mode = cfg[REG_CTRL][CTRL_MODE_BIT];
  assign opc_en = cfg[REG_CTRL][CTRL_OPC_EN_BIT];
  assign xa_bits = cfg[REG_CTRL][CTRL_XA_LSB +: 4];
  assign mem_code = cfg[REG_MEM_CFG][QUAL_LSB +: 3];
  assign io_code = cfg[REG_IO_CFG][QUAL_LSB];
  assign ix_mem_code = cfg[REG_IX_CFG][QUAL_LSB +: 3];
  assign ix_io_code = cfg[REG_IX_CFG][QUAL_IO_BIT];
  // Live until every qualifier of the selected mode is at its off code.
  assign next_active = (mode == MODE_SEPARATE) ? (mem_code != mem_off || io_code != IO_OFF)
                     : (ix_mem_code != mem_off || ix_io_code != IO_OFF);

  // ==========================================================
  // Opcode range set
  logic [15:0] rng_lo [0:NUM_RANGES-1];
  logic [15:0] rng_hi [0:NUM_RANGES-1];
  logic [NUM_RANGES-1:0] rng_used;
  logic [NUM_RANGES-1:0] rng_hit;
  logic [NUM_RANGES-1:0] rng_same;
  logic [NUM_RANGES-1:0] add_sel;
  logic [15:0] opc_masked;
  logic [15:0] new_lo;
  logic [15:0] new_hi;
  logic opc_add;
  logic [7:0] used_count;

  assign opc_masked = cyc_data & OPC_MASK;
  assign new_lo = cfg[REG_OPC_BOUNDS][15:0] & OPC_MASK;
  assign new_hi = cfg[REG_OPC_BOUNDS][31:16] & OPC_MASK;
  assign opc_add = pwdata[OPC_ADD_BIT];

  // First free slot wins an add; a full set drops the add silently.
  always_comb begin
    logic found;
    found = 1'b0;
    add_sel = '0;
    used_count = 8'h00;
    for (int i = 0; i < NUM_RANGES; i++) begin
      if (!rng_used[i] && !found) begin
        add_sel[i] = 1'b1;
        found = 1'b1;
      end
      used_count = used_count + {7'h00, rng_used[i]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_RANGES; g++) begin : slot
      assign rng_hit[g] = rng_used[g] && opc_masked >= rng_lo[g] && opc_masked <= rng_hi[g];
      assign rng_same[g] = rng_lo[g] == new_lo && rng_hi[g] == new_hi;
      // Ranges stay until a delete names the same bounds.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rng_used[g] <= 1'b0;
          rng_lo[g] <= 16'h0000;
          rng_hi[g] <= 16'h0000;
        end else if (opc_cmd_pulse && opc_add && add_sel[g] && !(|(rng_used & rng_same))) begin
          rng_used[g] <= 1'b1;
          rng_lo[g] <= new_lo;
          rng_hi[g] <= new_hi;
        end else if (opc_cmd_pulse && !opc_add && rng_used[g] && rng_same[g]) begin
          rng_used[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Qualification terms
  logic [15:0] io_addr;
  logic mem_cyc;
  logic fetch_qual;
  logic next_seen;
  logic sep_mem_hit;
  logic sep_io_hit;
  logic ix_hit;
  logic next_store;

  assign mem_cyc = cyc_valid && !cyc_io;
  assign io_addr = cyc_addr & IO_ADDR_MASK;

  // Fetch qualification: range, extended field, optional opcode set.
  assign fetch_qual = addr_ok(cyc_addr, cfg[REG_IX_ADDR1][15:0], cfg[REG_IX_ADDR2][15:0],
                              cfg[REG_IX_CFG][QUAL_RANGE_BIT])
                   && ext_ok(cyc_ext, cfg[REG_IX_CFG], xa_bits)
                   && (!opc_en || |rng_hit);

  // Separate memory qualifier, with data word compare.
  assign sep_mem_hit = mem_cyc && mem_ok(mem_code, cyc_write, instruction_fetch_cycle)
                    && addr_ok(cyc_addr, cfg[REG_MEM_ADDR1][15:0], cfg[REG_MEM_ADDR2][15:0],
                               cfg[REG_MEM_CFG][QUAL_RANGE_BIT])
                    && ((cyc_data ^ cfg[REG_MEM_DATA][15:0]) & cfg[REG_MEM_DATA][DMASK_LSB +: 16]) == 16'h0000
                    && ext_ok(cyc_ext, cfg[REG_MEM_CFG], xa_bits);

  // I/O qualifier has no data word compare, only the extended byte.
  assign sep_io_hit = cyc_valid && cyc_io && io_code == IO_ANY_ACCESS
                   && addr_ok(io_addr, cfg[REG_IO_ADDR1][15:0] & IO_ADDR_MASK,
                              cfg[REG_IO_ADDR2][15:0] & IO_ADDR_MASK,
                              cfg[REG_IO_CFG][QUAL_RANGE_BIT])
                   && ext_ok(cyc_ext, cfg[REG_IO_CFG], xa_bits);

  // A fetch updates the flag first, so a qualified fetch may store itself.
  always_comb begin
    next_seen = fetch_seen;
    if (mode == MODE_INSTR_RANGE && cyc_valid && !cyc_io && instruction_fetch_cycle) begin
      next_seen = fetch_qual;
    end else if (run_pulse) begin
      next_seen = 1'b0;
    end
  end

  // Cycles after a qualified fetch have no address limit.
  assign ix_hit = next_seen
               && ((mem_cyc && mem_ok(ix_mem_code, cyc_write, instruction_fetch_cycle))
               || (cyc_valid && cyc_io && ix_io_code == IO_ANY_ACCESS));

  assign next_store = (mode == MODE_SEPARATE) ? (sep_mem_hit || sep_io_hit) : ix_hit;

  // ==========================================================
  // Flag and sample registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_seen <= 1'b0;
    end else begin
      fetch_seen <= next_seen;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_active <= 1'b0;
    end else begin
      trace_active <= next_active;
    end
  end

  // Data is latched for I/O too and marked as from the addressed port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_store <= 1'b0;
      sample_is_io <= 1'b0;
      sample_addr <= 16'h0000;
      sample_data <= 16'h0000;
      sample_ext <= 8'h00;
    end else begin
      sample_store <= next_store;
      if (next_store) begin
        sample_is_io <= cyc_io;
        sample_addr <= cyc_io ? io_addr : cyc_addr;
        sample_data <= cyc_data;
        sample_ext <= cyc_ext;
      end
    end
  end

  assign status_word = {16'h0000, used_count, 6'h00, trace_active, fetch_seen};

  // ==========================================================
  // Checks
  io_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_SEPARATE && io_code == IO_OFF && cyc_valid && cyc_io |=> !sample_store)
    else $error("I/O cycle stored with I/O qualifier off.");
  io_exact_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_SEPARATE && io_code == IO_ANY_ACCESS && cyc_valid && cyc_io
    && !cfg[REG_IO_CFG][QUAL_RANGE_BIT] && cfg[REG_IO_CFG][QUAL_XMASK_LSB +: 8] == 8'h00
    && cyc_addr[14:0] == cfg[REG_IO_ADDR1][14:0] |=> sample_store && sample_is_io)
    else $error("Matching I/O cycle not stored.");
  io_bit15_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_store && sample_is_io |-> !sample_addr[15])
    else $error("I/O sample kept address bit 15.");
  fetch_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_INSTR_RANGE && cyc_valid && !cyc_io && instruction_fetch_cycle && fetch_qual
    |=> fetch_seen)
    else $error("Qualified fetch did not set the flag.");
  fetch_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_seen && mode == MODE_INSTR_RANGE && cyc_valid && !cyc_io && instruction_fetch_cycle
    && !fetch_qual |=> !fetch_seen)
    else $error("Unqualified fetch left the flag set.");
  ix_io_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_INSTR_RANGE && fetch_seen && cyc_valid && cyc_io && ix_io_code == IO_ANY_ACCESS
    && !run_pulse |=> sample_store ##0 sample_is_io)
    else $error("I/O cycle after qualified fetch not stored.");
  mem_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_SEPARATE && mem_code == mem_write_access && mem_cyc && !cyc_write
    && !sep_io_hit |=> !sample_store)
    else $error("Read stored under write-only qualifier.");
  run_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_pulse && !(cyc_valid && instruction_fetch_cycle) |=> !fetch_seen)
    else $error("Run start did not clear the flag.");
  active_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_store |-> $past(next_active))
    else $error("Sample stored while all qualifiers off.");
  // Without the flag no cycle but a fetch can open the instruction-range path.
  ix_armed_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_INSTR_RANGE && !fetch_seen && !(cyc_valid && !cyc_io && instruction_fetch_cycle)
    |=> !sample_store)
    else $error("Cycle stored with the fetch flag clear.");
  hold_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sample_store |-> $stable(sample_addr) && $stable(sample_data) && $stable(sample_ext)
    && $stable(sample_is_io))
    else $error("Sample fields moved without a store.");

  io_store_c: cover property (@(posedge pclk) disable iff (!presetn) sample_store && sample_is_io);
  ix_chain_c: cover property (@(posedge pclk) disable iff (!presetn)
    !fetch_seen ##1 fetch_seen ##[1:4] sample_store && !sample_is_io);
  opc_hit_c: cover property (@(posedge pclk) disable iff (!presetn) opc_en && |rng_hit && fetch_qual);
  excl_c: cover property (@(posedge pclk) disable iff (!presetn)
    sep_mem_hit && cfg[REG_MEM_CFG][QUAL_RANGE_BIT]
    && cfg[REG_MEM_ADDR1][15:0] > cfg[REG_MEM_ADDR2][15:0]);
  ix_io_c: cover property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_INSTR_RANGE && sample_store && sample_is_io);

endmodule

// *** verilog/trace_qual_pkg.sv ***
package trace_qual_pkg;
  // ==========================================================
  // Register word indexes, byte address is four times the index.
  localparam int unsigned REG_CTRL = 0;
  localparam int unsigned REG_MEM_CFG = 1;
  localparam int unsigned REG_MEM_ADDR1 = 2;
  localparam int unsigned REG_MEM_ADDR2 = 3;
  localparam int unsigned REG_MEM_DATA = 4;
  localparam int unsigned REG_IO_CFG = 5;
  localparam int unsigned REG_IO_ADDR1 = 6;
  localparam int unsigned REG_IO_ADDR2 = 7;
  localparam int unsigned REG_IX_CFG = 8;
  localparam int unsigned REG_IX_ADDR1 = 9;
  localparam int unsigned REG_IX_ADDR2 = 10;
  localparam int unsigned REG_OPC_BOUNDS = 11;
  localparam int unsigned REG_OPC_CMD = 12;
  localparam int unsigned REG_STATUS = 13;
  localparam int unsigned NUM_REGS = 14;
  // ==========================================================
  // Control word fields.
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_OPC_EN_BIT = 1;
  localparam int unsigned CTRL_XA_LSB = 4;
  localparam int unsigned CTRL_RUN_BIT = 8;
  // Qualifier word fields, shared by the three setups.
  localparam int unsigned QUAL_LSB = 0;
  localparam int unsigned QUAL_RANGE_BIT = 3;
  localparam int unsigned QUAL_IO_BIT = 4;
  localparam int unsigned QUAL_XCMP_LSB = 8;
  localparam int unsigned QUAL_XMASK_LSB = 16;
  // Compare word: value low half, mask high half.
  localparam int unsigned DMASK_LSB = 16;
  // Opcode command word.
  localparam int unsigned OPC_ADD_BIT = 0;
  // Status word.
  localparam int unsigned STAT_SEEN_BIT = 0;
  localparam int unsigned STAT_ACTIVE_BIT = 1;
  localparam int unsigned STAT_USED_LSB = 8;
  // ==========================================================
  // Reset values and fixed constants.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] OPC_MASK = 16'hFFF0;
  localparam logic [15:0] IO_ADDR_MASK = 16'h7FFF;
  localparam logic [7:0] EXT_ALL = 8'hFF;
  localparam logic [3:0] EXT_BITS = 4'h8;
  // ==========================================================
  // Qualifier codes.
  typedef enum logic [2:0] {
    mem_off = 3'h0,
    mem_any_access = 3'h1,
    mem_read_access = 3'h2,
    mem_write_access = 3'h3,
    mem_fetch_only = 3'h4
  } mem_qual_t;
  localparam logic IO_OFF = 1'b0;
  localparam logic IO_ANY_ACCESS = 1'b1;
  localparam logic MODE_SEPARATE = 1'b0;
  localparam logic MODE_INSTR_RANGE = 1'b1;
endpackage
